// ---- rtl/ldx_pkg.sv ----
// shared constants and types of the load instruction executer
package ldx_pkg;
  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [3:0] NIB_IMM = 4'hc;
  localparam logic [3:0] NIB_LDR = 4'h8;
  localparam logic [3:0] NIB_STR = 4'h9;
  localparam logic [7:0] OP_LD_IND = 8'hc7;
  localparam logic [7:0] OP_ST_IND = 8'hd7;
  localparam logic [7:0] OP_R_R = 8'he4;
  localparam logic [7:0] OP_R_IND = 8'he5;
  localparam logic [7:0] OP_R_IMM = 8'he6;
  localparam logic [7:0] OP_IND_IMM = 8'hd6;
  localparam logic [7:0] OP_IND_R = 8'hf5;
  localparam logic [7:0] OP_LD_IDX = 8'h87;
  localparam logic [7:0] OP_ST_IDX = 8'h97;
  localparam logic [7:0] OP_BIT = 8'h47;
  localparam logic [7:0] OP_MLD = 8'hc3;
  localparam logic [7:0] OP_MST = 8'hd3;
  localparam logic [7:0] OP_MLD_SO = 8'he7;
  localparam logic [7:0] OP_MST_SO = 8'hf7;
  localparam logic [7:0] OP_MLD_LO = 8'ha7;
  localparam logic [7:0] OP_MST_LO = 8'hb7;
  // pair fields that mean absolute_address with the long form
  localparam logic [2:0] PAIR_DIRECT = 3'h0;
  // ----------------------------------------------------------------
  // lengths and cycle counts
  // ----------------------------------------------------------------
  localparam logic [2:0] LEN_2 = 3'h2;
  localparam logic [2:0] LEN_3 = 3'h3;
  localparam logic [2:0] LEN_4 = 3'h4;
  localparam logic [3:0] CYC_SHORT = 4'h4;
  localparam logic [3:0] CYC_LONG = 4'h6;
  localparam logic [3:0] CYC_MEM = 4'ha;
  localparam logic [3:0] CYC_MEM_SO = 4'hc;
  localparam logic [3:0] CYC_MEM_LO = 4'he;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CL_BAD, CL_IMM, CL_LDR, CL_STR, CL_LD_IND, CL_ST_IND, CL_R_R,
    CL_R_IND, CL_R_IMM, CL_IND_IMM, CL_IND_R, CL_LD_IDX, CL_ST_IDX,
    CL_BIT, CL_MLD, CL_MST
  } ldx_cls_t;
  typedef enum logic [1:0] {M_IMM, M_REG, M_PTR} ldx_mode_t;
endpackage

// ---- rtl/ldx_dec_if.sv ----
// decode request and answer between the executer and its decoder
`timescale 1ns/1ps
interface ldx_dec_if;
  logic [7:0] opcode;
  ldx_pkg::ldx_cls_t cls;
  logic [2:0] nbytes;
  logic [3:0] ncyc;
  modport dec (input opcode, output cls, nbytes, ncyc);
  modport use_side (output opcode, input cls, nbytes, ncyc);
endinterface

// ---- rtl/ldx_dec.sv ----
// opcode decoder: instruction class, length and cycle count
`timescale 1ns/1ps
module ldx_dec (
  ldx_dec_if.dec d
);
  // ----------------------------------------------------------------
  // class lookup
  // ----------------------------------------------------------------
  // full opcodes first, then the working register nibble forms
  always_comb
  begin
    d.cls = ldx_pkg::CL_BAD;
    d.nbytes = ldx_pkg::LEN_2;
    d.ncyc = ldx_pkg::CYC_SHORT;
    case (d.opcode)
      ldx_pkg::OP_LD_IND: d.cls = ldx_pkg::CL_LD_IND;
      ldx_pkg::OP_ST_IND: d.cls = ldx_pkg::CL_ST_IND;
      ldx_pkg::OP_MLD:
      begin
        d.cls = ldx_pkg::CL_MLD;
        d.ncyc = ldx_pkg::CYC_MEM;
      end
      ldx_pkg::OP_MST:
      begin
        d.cls = ldx_pkg::CL_MST;
        d.ncyc = ldx_pkg::CYC_MEM;
      end
      ldx_pkg::OP_MLD_SO, ldx_pkg::OP_MST_SO:
      begin
        d.cls = d.opcode[4] ? ldx_pkg::CL_MST : ldx_pkg::CL_MLD;
        d.nbytes = ldx_pkg::LEN_3;
        d.ncyc = ldx_pkg::CYC_MEM_SO;
      end
      ldx_pkg::OP_MLD_LO, ldx_pkg::OP_MST_LO:
      begin
        d.cls = d.opcode[4] ? ldx_pkg::CL_MST : ldx_pkg::CL_MLD;
        d.nbytes = ldx_pkg::LEN_4;
        d.ncyc = ldx_pkg::CYC_MEM_LO;
      end
      default:
      begin
        d.nbytes = ldx_pkg::LEN_3;
        d.ncyc = ldx_pkg::CYC_LONG;
        case (d.opcode)
          ldx_pkg::OP_R_R: d.cls = ldx_pkg::CL_R_R;
          ldx_pkg::OP_R_IND: d.cls = ldx_pkg::CL_R_IND;
          ldx_pkg::OP_R_IMM: d.cls = ldx_pkg::CL_R_IMM;
          ldx_pkg::OP_IND_IMM: d.cls = ldx_pkg::CL_IND_IMM;
          ldx_pkg::OP_IND_R: d.cls = ldx_pkg::CL_IND_R;
          ldx_pkg::OP_LD_IDX: d.cls = ldx_pkg::CL_LD_IDX;
          ldx_pkg::OP_ST_IDX: d.cls = ldx_pkg::CL_ST_IDX;
          ldx_pkg::OP_BIT: d.cls = ldx_pkg::CL_BIT;
          default:
          begin
            // working register in the high nibble
            d.nbytes = ldx_pkg::LEN_2;
            d.ncyc = ldx_pkg::CYC_SHORT;
            case (d.opcode[3:0])
              ldx_pkg::NIB_IMM: d.cls = ldx_pkg::CL_IMM;
              ldx_pkg::NIB_LDR: d.cls = ldx_pkg::CL_LDR;
              ldx_pkg::NIB_STR: d.cls = ldx_pkg::CL_STR;
              default: d.cls = ldx_pkg::CL_BAD;
            endcase
          end
        endcase
      end
    endcase
  end
endmodule

// ---- rtl/ldx_exec.sv ----
// executer for byte, bit and memory move instructions
// Summary of operation
// - byte_move copies source into destination, source left as it was
// - none of these moves touches any flag bit
// - low nibble C, 8, 9: high nibble working reg; 2 bytes, 4 cycles
// - C7 loads via pointer reg, D7 stores via it; 2 bytes, 4 cycles
// - E4, E5, E6, D6, F5 three byte moves in six cycles
// - 87 loads, 97 stores at offset byte plus working reg; 6 cycles
// - bit load puts chosen bit into bit 0, other bits kept
// - bit store puts bit 0 into chosen bit, other bits kept
// - opcode 47, byte two holds reg, bit index, direction; 6 cycles
// - memory moves carry one byte between working reg and memory
// - even pair field picks program memory, odd picks data memory
// - C3 loads, D3 stores at pair address; 2 bytes, 10 cycles
// - E7, F7 add short_offset byte to pair; 3 bytes, 12 cycles
// - A7, B7 add long_offset low then high; 4 bytes, 14 cycles
// - long_offset form never uses pair 0-1; such fields go direct
// - pair 0000 direct program address, 0001 direct data address
`timescale 1ns/1ps
module ldx_exec (
  input wire logic REF_CLK_I,
  input wire logic RST_B_I,
  input wire logic [3:0] WBANK_I,
  input wire logic FETCH_VALID_I,
  input wire logic [7:0] FETCH_BYTE_I,
  output logic FETCH_READY_O,
  input wire logic [7:0] RF_RD_DATA_I,
  output logic [7:0] RF_ADDR_O,
  output logic RF_RE_O,
  output logic RF_WE_O,
  output logic [7:0] RF_WDATA_O,
  input wire logic [7:0] MEM_RD_DATA_I,
  output logic [15:0] MEM_ADDR_O,
  output logic MEM_DATA_SEL_O,
  output logic MEM_RE_O,
  output logic MEM_WE_O,
  output logic [7:0] MEM_WDATA_O,
  output logic DONE_O,
  output logic ILLEGAL_O
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    S_IDLE, S_FETCH, S_SPTR, S_SVAL, S_DPTR, S_DOLD, S_PH, S_PL,
    S_MEM, S_WR
  } ldx_st_t;
  typedef struct packed {
    ldx_st_t st;
    logic [3:0][7:0] b;
    logic [1:0] idx;
    logic [3:0] cnt;
    logic [3:0] ncyc;
    ldx_pkg::ldx_cls_t cls;
    ldx_pkg::ldx_mode_t smode;
    ldx_pkg::ldx_mode_t dmode;
    logic [7:0] saddr;
    logic [7:0] soff;
    logic [7:0] daddr;
    logic [7:0] doff;
    logic [7:0] val;
    logic [7:0] old;
    logic bitv;
    logic direct;
    logic [15:0] maddr;
    logic rdy;
    logic [7:0] rf_addr;
    logic rf_re;
    logic rf_we;
    logic msel;
    logic m_re;
    logic m_we;
    logic done;
    logic ill;
  } ldx_state_t;
  ldx_state_t q;
  ldx_state_t n;
  logic [3:0][7:0] bn;
  logic take;
  logic go_dst;
  logic fin;
  logic [3:0] hi;
  logic [3:0] lo;
  logic [2:0] bidx;
  logic load_dir;
  logic [15:0] off16;
  ldx_dec_if dif ();

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  // bytes held so far merged with the one being taken
  assign take = FETCH_VALID_I && q.rdy;
  // an opcode always lands in byte 0, whatever index was left over
  always_comb
  begin
    bn = q.b;
    if (take)
      bn[(q.st == S_IDLE) ? 2'h0 : q.idx] = FETCH_BYTE_I;
  end
  assign dif.opcode = bn[0];
  assign hi = bn[1][7:4];
  assign lo = bn[1][3:0];
  assign bidx = q.b[1][3:1];
  assign load_dir = !q.b[1][0];
  // short_offset is one byte, long_offset low then high
  assign off16 = (q.ncyc == ldx_pkg::CYC_MEM_LO) ? {q.b[3], q.b[2]} :
                 (q.ncyc == ldx_pkg::CYC_MEM_SO) ? {8'h00, q.b[2]} :
                 16'h0000;
  ldx_dec u_dec (
    .d(dif)
  );

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    n = q;
    go_dst = 1'b0;
    fin = 1'b0;
    n.rf_re = 1'b0;
    n.rf_we = 1'b0;
    n.m_re = 1'b0;
    n.m_we = 1'b0;
    n.done = 1'b0;
    n.ill = 1'b0;
    n.cnt = q.cnt + 4'h1;
    unique case (q.st)
      S_IDLE:
      begin
        n.cnt = 4'h1;
        n.idx = 2'h1;
        n.b = bn;
        if (!take)
          n.cnt = q.cnt;
        else if (dif.cls == ldx_pkg::CL_BAD)
          n.ill = 1'b1;
        else
          n.st = S_FETCH;
      end
      S_FETCH:
      begin
        if (!take)
          n.cnt = q.cnt;
        else
          n.idx = q.idx + 2'h1;
        n.b = bn;
        if (take && {1'b0, q.idx} == dif.nbytes - 3'h1)
        begin
          // last byte: set up operands and start the first access
          n.cls = dif.cls;
          n.ncyc = dif.ncyc;
          n.smode = ldx_pkg::M_REG;
          n.dmode = ldx_pkg::M_REG;
          n.soff = 8'h00;
          n.doff = 8'h00;
          n.saddr = bn[1];
          n.daddr = {WBANK_I, bn[0][7:4]};
          n.direct = 1'b0;
          unique case (dif.cls)
            ldx_pkg::CL_IMM:
            begin
              n.smode = ldx_pkg::M_IMM;
              n.val = bn[1];
            end
            ldx_pkg::CL_LDR: n.smode = ldx_pkg::M_REG;
            ldx_pkg::CL_STR:
            begin
              n.saddr = {WBANK_I, bn[0][7:4]};
              n.daddr = bn[1];
            end
            ldx_pkg::CL_LD_IND:
            begin
              n.smode = ldx_pkg::M_PTR;
              n.saddr = {WBANK_I, lo};
              n.daddr = {WBANK_I, hi};
            end
            ldx_pkg::CL_ST_IND:
            begin
              n.saddr = {WBANK_I, lo};
              n.dmode = ldx_pkg::M_PTR;
              n.daddr = {WBANK_I, hi};
            end
            ldx_pkg::CL_R_R, ldx_pkg::CL_R_IND, ldx_pkg::CL_IND_R:
            begin
              n.daddr = bn[2];
              if (dif.cls == ldx_pkg::CL_R_IND)
                n.smode = ldx_pkg::M_PTR;
              if (dif.cls == ldx_pkg::CL_IND_R)
                n.dmode = ldx_pkg::M_PTR;
            end
            ldx_pkg::CL_R_IMM, ldx_pkg::CL_IND_IMM:
            begin
              n.smode = ldx_pkg::M_IMM;
              n.val = bn[2];
              n.daddr = bn[1];
              if (dif.cls == ldx_pkg::CL_IND_IMM)
                n.dmode = ldx_pkg::M_PTR;
            end
            ldx_pkg::CL_LD_IDX:
            begin
              n.smode = ldx_pkg::M_PTR;
              n.saddr = {WBANK_I, lo};
              n.soff = bn[2];
              n.daddr = {WBANK_I, hi};
            end
            ldx_pkg::CL_ST_IDX:
            begin
              n.saddr = {WBANK_I, hi};
              n.dmode = ldx_pkg::M_PTR;
              n.daddr = {WBANK_I, lo};
              n.doff = bn[2];
            end
            ldx_pkg::CL_BIT:
            begin
              // direction bit picks which side is the working reg
              n.saddr = bn[1][0] ? {WBANK_I, hi} : bn[2];
              n.daddr = bn[1][0] ? bn[2] : {WBANK_I, hi};
            end
            ldx_pkg::CL_MLD, ldx_pkg::CL_MST:
            begin
              n.msel = lo[0];
              n.direct = dif.ncyc == ldx_pkg::CYC_MEM_LO &&
                         lo[3:1] == ldx_pkg::PAIR_DIRECT;
              n.maddr = {bn[3], bn[2]};
              n.daddr = {WBANK_I, hi};
              n.saddr = {WBANK_I, hi};
            end
            default: n.st = S_IDLE;
          endcase
          // first access
          n.rf_re = 1'b1;
          n.rf_addr = n.saddr;
          if (n.direct && dif.cls == ldx_pkg::CL_MLD)
          begin
            n.rf_re = 1'b0;
            n.m_re = 1'b1;
            n.st = S_MEM;
          end
          else if (n.direct)
            n.st = S_SVAL;
          else if (dif.cls == ldx_pkg::CL_MLD ||
                   dif.cls == ldx_pkg::CL_MST)
          begin
            // pair address uses the even register
            n.rf_addr = {WBANK_I, lo[3:1], 1'b0};
            n.st = S_PH;
          end
          else if (n.smode == ldx_pkg::M_PTR)
            n.st = S_SPTR;
          else if (n.smode == ldx_pkg::M_REG)
            n.st = S_SVAL;
          else
          begin
            n.rf_re = 1'b0;
            go_dst = 1'b1;
          end
        end
      end
      S_PH:
      begin
        n.maddr[15:8] = RF_RD_DATA_I;
        n.rf_re = 1'b1;
        n.rf_addr = {WBANK_I, q.b[1][3:1], 1'b1};
        n.st = S_PL;
      end
      S_PL:
      begin
        n.maddr = {q.maddr[15:8], RF_RD_DATA_I} + off16;
        if (q.cls == ldx_pkg::CL_MLD)
        begin
          n.m_re = 1'b1;
          n.st = S_MEM;
        end
        else
        begin
          n.rf_re = 1'b1;
          n.rf_addr = q.saddr;
          n.st = S_SVAL;
        end
      end
      S_MEM:
      begin
        n.val = MEM_RD_DATA_I;
        fin = 1'b1;
      end
      S_SPTR:
      begin
        // pointer contents become the source address
        n.saddr = RF_RD_DATA_I + q.soff;
        n.rf_re = 1'b1;
        n.rf_addr = n.saddr;
        n.st = S_SVAL;
      end
      S_SVAL:
      begin
        n.val = RF_RD_DATA_I;
        n.bitv = load_dir ? RF_RD_DATA_I[bidx] : RF_RD_DATA_I[0];
        if (q.cls == ldx_pkg::CL_MST)
          fin = 1'b1;
        else
          go_dst = 1'b1;
      end
      S_DPTR:
      begin
        n.daddr = RF_RD_DATA_I + q.doff;
        fin = 1'b1;
      end
      S_DOLD:
      begin
        n.old = RF_RD_DATA_I;
        if (load_dir)
          n.val = {RF_RD_DATA_I[7:1], q.bitv};
        else
          n.val = (RF_RD_DATA_I & ~(8'h01 << bidx)) |
                  ({7'h00, q.bitv} << bidx);
        fin = 1'b1;
      end
      S_WR: fin = 1'b1;
    endcase
    // destination side: pointer first, then old value for a bit move
    if (go_dst)
    begin
      n.rf_re = n.dmode == ldx_pkg::M_PTR || n.cls == ldx_pkg::CL_BIT;
      n.rf_addr = n.daddr;
      if (n.dmode == ldx_pkg::M_PTR)
        n.st = S_DPTR;
      else if (n.cls == ldx_pkg::CL_BIT)
        n.st = S_DOLD;
      else
        fin = 1'b1;
    end
    // single write once the instruction has used its cycles
    if (fin)
    begin
      if (q.cnt >= n.ncyc - 4'h1)
      begin
        // only the destination is written, never the flags
        n.m_we = n.cls == ldx_pkg::CL_MST;
        n.rf_we = !n.m_we;
        n.rf_addr = n.daddr;
        n.done = 1'b1;
        n.st = S_IDLE;
      end
      else
        n.st = S_WR;
    end
    n.rdy = n.st == S_IDLE || n.st == S_FETCH;
  end

  // ----------------------------------------------------------------
  // registers and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge RST_B_I)
  begin
    if (!RST_B_I)
      q <= '0;
    else
      q <= n;
  end
  assign FETCH_READY_O = q.rdy;
  assign RF_ADDR_O = q.rf_addr;
  assign RF_RE_O = q.rf_re;
  assign RF_WE_O = q.rf_we;
  assign RF_WDATA_O = q.val;
  assign MEM_ADDR_O = q.maddr;
  assign MEM_DATA_SEL_O = q.msel;
  assign MEM_RE_O = q.m_re;
  assign MEM_WE_O = q.m_we;
  assign MEM_WDATA_O = q.val;
  assign DONE_O = q.done;
  assign ILLEGAL_O = q.ill;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_one_write;
    @(posedge REF_CLK_I) disable iff (!RST_B_I)
    (RF_WE_O || MEM_WE_O) |-> DONE_O ##1 !(RF_WE_O || MEM_WE_O);
  endproperty
  a_one_write: assert property (p_one_write)
    else $error("write outside instruction end");
  property p_plain_value;
    @(posedge REF_CLK_I) disable iff (!RST_B_I)
    RF_WE_O && q.cls == ldx_pkg::CL_R_R
      |-> RF_WDATA_O == $past(RF_RD_DATA_I, 3);
  endproperty
  a_plain_value: assert property (p_plain_value)
    else $error("byte move wrote wrong value");
  property p_short_len;
    @(posedge REF_CLK_I) disable iff (!RST_B_I)
    DONE_O && q.cls inside {ldx_pkg::CL_IMM, ldx_pkg::CL_LDR,
      ldx_pkg::CL_STR} |-> q.cnt == 4'h4;
  endproperty
  a_short_len: assert property (p_short_len)
    else $error("working reg move not four cycles");
  property p_ind_len;
    @(posedge REF_CLK_I) disable iff (!RST_B_I)
    DONE_O && q.cls inside {ldx_pkg::CL_LD_IND, ldx_pkg::CL_ST_IND}
      |-> q.cnt == 4'h4 && RF_WE_O;
  endproperty
  a_ind_len: assert property (p_ind_len)
    else $error("indirect move not four cycles");
  property p_long_len;
    @(posedge REF_CLK_I) disable iff (!RST_B_I)
    DONE_O && q.cls inside {ldx_pkg::CL_R_R, ldx_pkg::CL_R_IMM,
      ldx_pkg::CL_IND_R, ldx_pkg::CL_LD_IDX, ldx_pkg::CL_BIT}
      |-> q.cnt == 4'h6;
  endproperty
  a_long_len: assert property (p_long_len)
    else $error("three byte move not six cycles");
  property p_bit_load;
    @(posedge REF_CLK_I) disable iff (!RST_B_I)
    RF_WE_O && q.cls == ldx_pkg::CL_BIT && load_dir
      |-> RF_WDATA_O[7:1] == q.old[7:1] && RF_WDATA_O[0] == q.bitv;
  endproperty
  a_bit_load: assert property (p_bit_load)
    else $error("bit load disturbed other bits");
  property p_bit_store;
    @(posedge REF_CLK_I) disable iff (!RST_B_I)
    RF_WE_O && q.cls == ldx_pkg::CL_BIT && !load_dir
      |-> RF_WDATA_O[bidx] == q.bitv;
  endproperty
  a_bit_store: assert property (p_bit_store)
    else $error("bit store missed chosen bit");
  property p_mem_space;
    @(posedge REF_CLK_I) disable iff (!RST_B_I)
    MEM_RE_O || MEM_WE_O |-> MEM_DATA_SEL_O == q.b[1][0];
  endproperty
  a_mem_space: assert property (p_mem_space)
    else $error("memory space not from pair field");
  property p_mem_len;
    @(posedge REF_CLK_I) disable iff (!RST_B_I)
    DONE_O && q.cls inside {ldx_pkg::CL_MLD, ldx_pkg::CL_MST}
      |-> q.cnt inside {4'ha, 4'hc, 4'he};
  endproperty
  a_mem_len: assert property (p_mem_len)
    else $error("memory move length wrong");
  property p_direct;
    @(posedge REF_CLK_I) disable iff (!RST_B_I)
    (MEM_RE_O || MEM_WE_O) && q.direct |-> MEM_ADDR_O == {q.b[3], q.b[2]};
  endproperty
  a_direct: assert property (p_direct)
    else $error("direct address not taken from bytes");
endmodule

// ---- test/load_instruction_execute_bench.sv ----
// self-checking bench for the load instruction executer
`timescale 1ns/1ps
module load_instruction_execute_bench;
  // ----------------------------------------------------------------
  // clock, models and counters
  // ----------------------------------------------------------------
  logic clk;
  logic rst_b;
  logic [3:0] wbank;
  logic fvalid;
  logic [7:0] fbyte;
  logic fready;
  logic [7:0] rf_rd;
  logic [7:0] rf_addr;
  logic rf_re;
  logic rf_we;
  logic [7:0] rf_wd;
  logic [7:0] mem_rd;
  logic [15:0] mem_addr;
  logic mem_sel;
  logic mem_re;
  logic mem_we;
  logic [7:0] mem_wd;
  logic done;
  logic illegal;
  logic [7:0] rf [0:255];
  logic [7:0] pm [0:65535];
  logic [7:0] dm [0:65535];
  logic [7:0] junk;
  int writes;
  int mismatches;
  int samples_checked;

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // read data only valid under a strobe, else a moving pattern
  assign rf_rd = rf_re ? rf[rf_addr] : junk;
  assign mem_rd = !mem_re ? ~junk : (mem_sel ? dm[mem_addr] : pm[mem_addr]);

  // register file and memories take writes, count them
  always @(posedge clk)
  begin
    junk <= junk + 8'h3b;
    if (rf_we === 1'b1)
    begin
      rf[rf_addr] <= rf_wd;
      writes++;
    end
    if (mem_we === 1'b1)
    begin
      if (mem_sel) dm[mem_addr] <= mem_wd;
      else pm[mem_addr] <= mem_wd;
      writes++;
    end
  end

  ldx_exec ldx_exec_i (
    .REF_CLK_I(clk), .RST_B_I(rst_b), .WBANK_I(wbank),
    .FETCH_VALID_I(fvalid), .FETCH_BYTE_I(fbyte), .FETCH_READY_O(fready),
    .RF_RD_DATA_I(rf_rd), .RF_ADDR_O(rf_addr), .RF_RE_O(rf_re),
    .RF_WE_O(rf_we), .RF_WDATA_O(rf_wd), .MEM_RD_DATA_I(mem_rd),
    .MEM_ADDR_O(mem_addr), .MEM_DATA_SEL_O(mem_sel), .MEM_RE_O(mem_re),
    .MEM_WE_O(mem_we), .MEM_WDATA_O(mem_wd), .DONE_O(done),
    .ILLEGAL_O(illegal)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("mismatches %0d samples_checked %0d", mismatches,
             samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic ck(input string w, input logic [15:0] s,
                    input logic [15:0] e);
    samples_checked++;
    if (s !== e)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", w, e, s);
    end
  endtask

  // send n bytes (opcode in top byte), expect done after nc cycles
  task automatic ex(input logic [31:0] ins, input int n, input int nc);
    int i;
    int c;
    logic r;
    logic ok;
    i = 1;
    c = 0;
    writes = 0;
    fvalid = 1'b1;
    fbyte = ins[31:24];
    while (c < 20 && fready !== 1'b1)
    begin
      @(posedge clk);
      #1 c++;
    end
    ok = (fready === 1'b1);
    @(posedge clk);
    // cycle 1 is the one after the opcode edge
    #1 c = 1;
    while (c < 30 && done !== 1'b1)
    begin
      fvalid = (i < n);
      fbyte = (i < n) ? ins[31 - 8 * i -: 8] : ~fbyte;
      r = fready;
      @(posedge clk);
      #1 c++;
      if (r && i < n) i++;
    end
    fvalid = 1'b0;
    if (done !== 1'b1 || !ok)
    begin
      mismatches++;
      test_done();
    end
    else
    begin
      ck("cycles", c[15:0], nc[15:0]);
      ck("wr at done", {15'h0, rf_we | mem_we}, 16'h1);
      @(posedge clk);
      #1 ck("writes", writes[15:0], 16'h1);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_work;
    rf[8'h10] = 8'h77;
    ex({8'h5c, 8'ha5, 16'h0}, 2, 4);
    ck("r35", rf[8'h35], 8'ha5);
    ex({8'h68, 8'h10, 16'h0}, 2, 4);
    ck("r36", rf[8'h36], 8'h77);
    ck("r10", rf[8'h10], 8'h77);
    ex({8'h69, 8'h11, 16'h0}, 2, 4);
    ck("r11", rf[8'h11], 8'h77);
  endtask

  task automatic t_ptr;
    rf[8'h32] = 8'h40;
    rf[8'h40] = 8'h9c;
    ex({8'hc7, 8'h12, 16'h0}, 2, 4);
    ck("r31", rf[8'h31], 8'h9c);
    ck("r32", rf[8'h32], 8'h40);
    rf[8'h31] = 8'h5e;
    ex({8'hd7, 8'h21, 16'h0}, 2, 4);
    ck("r40", rf[8'h40], 8'h5e);
  endtask

  task automatic t_three;
    rf[8'h20] = 8'h12;
    rf[8'h22] = 8'h20;
    ex({8'he4, 8'h20, 8'h21, 8'h00}, 3, 6);
    ck("r21", rf[8'h21], 8'h12);
    ex({8'he5, 8'h22, 8'h23, 8'h00}, 3, 6);
    ck("r23", rf[8'h23], 8'h12);
    ex({8'he6, 8'h24, 8'ha1, 8'h00}, 3, 6);
    ck("r24", rf[8'h24], 8'ha1);
    ex({8'hd6, 8'h22, 8'hb2, 8'h00}, 3, 6);
    ck("r20", rf[8'h20], 8'hb2);
    ex({8'hf5, 8'h24, 8'h22, 8'h00}, 3, 6);
    ck("r20", rf[8'h20], 8'ha1);
  endtask

  task automatic t_index;
    rf[8'h37] = 8'h05;
    rf[8'h55] = 8'h6b;
    ex({8'h87, 8'h47, 8'h50, 8'h00}, 3, 6);
    ck("r34", rf[8'h34], 8'h6b);
    ex({8'h97, 8'h47, 8'hfe, 8'h00}, 3, 6);
    ck("r03", rf[8'h03], 8'h6b);
  endtask

  task automatic t_bit;
    rf[8'h30] = 8'h06;
    rf[8'h00] = 8'h05;
    ex({8'h47, 8'h04, 8'h00, 8'h00}, 3, 6);
    ck("r30", rf[8'h30], 8'h07);
    ck("r00", rf[8'h00], 8'h05);
    rf[8'h30] = 8'h06;
    ex({8'h47, 8'h01, 8'h00, 8'h00}, 3, 6);
    ck("r00", rf[8'h00], 8'h04);
    ck("r30", rf[8'h30], 8'h06);
  endtask

  task automatic t_mem;
    rf[8'h32] = 8'h01;
    rf[8'h33] = 8'h04;
    pm[16'h0104] = 8'h1a;
    dm[16'h0104] = 8'h2a;
    pm[16'h0105] = 8'h6d;
    pm[16'h1104] = 8'h88;
    dm[16'h1104] = 8'h98;
    ex({8'hc3, 8'h02, 16'h0}, 2, 10);
    ck("r30", rf[8'h30], 8'h1a);
    ex({8'hc3, 8'h03, 16'h0}, 2, 10);
    ck("r30", rf[8'h30], 8'h2a);
    rf[8'h30] = 8'h11;
    ex({8'hd3, 8'h02, 16'h0}, 2, 10);
    ck("p0104", pm[16'h0104], 8'h11);
    ex({8'hf7, 8'h03, 8'h01, 8'h00}, 3, 12);
    ck("d0105", dm[16'h0105], 8'h11);
    ex({8'he7, 8'h02, 8'h01, 8'h00}, 3, 12);
    ck("r30", rf[8'h30], 8'h6d);
    ex({8'ha7, 8'h02, 8'h00, 8'h10}, 4, 14);
    ck("r30", rf[8'h30], 8'h88);
    ex({8'hb7, 8'h03, 8'h01, 8'h10}, 4, 14);
    ck("d1105", dm[16'h1105], 8'h88);
    ex({8'ha7, 8'h01, 8'h04, 8'h11}, 4, 14);
    ck("r30", rf[8'h30], 8'h98);
    ex({8'hb7, 8'h00, 8'h06, 8'h11}, 4, 14);
    ck("p1106", pm[16'h1106], 8'h98);
  endtask

  task automatic t_illegal;
    logic seen;
    seen = 1'b0;
    writes = 0;
    fvalid = 1'b1;
    fbyte = 8'h00;
    @(posedge clk);
    #1 fvalid = 1'b0;
    repeat (3)
    begin
      seen = seen | (illegal === 1'b1);
      @(posedge clk);
      #1;
    end
    ck("illegal", {15'h0, seen}, 16'h1);
    ck("ready", {15'h0, fready}, 16'h1);
    ck("writes", writes[15:0], 16'h0);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_b = 1'b0;
    wbank = 4'h3;
    fvalid = 1'b0;
    fbyte = 8'h00;
    junk = 8'h5a;
    mismatches = 0;
    samples_checked = 0;
    writes = 0;
    for (int k = 0; k < 256; k++) rf[k] = 8'h00;
    repeat (4) @(posedge clk);
    #1 rst_b = 1'b1;
    t_work();
    t_ptr();
    t_three();
    t_index();
    t_bit();
    t_mem();
    t_illegal();
    test_done();
  end
endmodule
